// File: include/hasg_consts.svh
// Timing and address constants for the host access spacing guard.
// Assumes inclusion by bare name from the include folder.
`ifndef HASG_CONSTS_SVH
`define HASG_CONSTS_SVH

// ---------------------------------------------------------------
// Clock
// ---------------------------------------------------------------
`define HASG_CLK_PERIOD_PS   8000

// ---------------------------------------------------------------
// Minimum spacings in nanoseconds
// ---------------------------------------------------------------
`define HASG_FIFO_POP_NS     135
`define HASG_CSR_DATA_NS     50
`define HASG_TCFG_SELF_NS    55
`define HASG_TCFG_CNT_NS     170
`define HASG_TS_CFG_NS       70
`define HASG_TS_STS_NS       50
`define HASG_IRQ_WR_NS       60
`define HASG_DUMMY_CYC_NS    45

// Whole clock cycles, rounded up.
`define HASG_NS2CYC(ns) (((ns) * 1000 + `HASG_CLK_PERIOD_PS - 1) / \
   `HASG_CLK_PERIOD_PS)

// ---------------------------------------------------------------
// Word addresses of the resources involved (word index)
// ---------------------------------------------------------------
`define HASG_A_RX_DATA_FIFO  8'h00
`define HASG_A_RX_STS_FIFO   8'h10
`define HASG_A_TX_DATA_FIFO  8'h08
`define HASG_A_TX_STS_FIFO   8'h12
`define HASG_A_RX_FIFO_INFO  8'h1f
`define HASG_A_TX_FIFO_INFO  8'h20
`define HASG_A_IRQ_CFG       8'h15
`define HASG_A_GLB_IRQ_STS   8'h16
`define HASG_A_BYTE_TEST     8'h19
`define HASG_A_TIMER_CFG     8'h23
`define HASG_A_TIMER_CNT     8'h24
`define HASG_A_TS_CMD        8'h29
`define HASG_A_TS_IRQ_STS    8'h2a
`define HASG_A_TS_IRQ_EN     8'h2b
`define HASG_A_PIN_IRQ_STSEN 8'h7a
`define HASG_A_FAB_DATA      8'h6b
`define HASG_A_FAB_CMD       8'h6c

`endif

// File: include/hasg_pkg.sv
// Types shared by both ends of the host access spacing guard.
// Assumes the constants header is available on the include path.
package hasg_pkg;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef logic [7:0]  hasg_addr_t;
   typedef logic [15:0] hasg_data_t;

   // Width of one bus cycle.
   typedef enum logic [1:0] {
      HASG_W8,
      HASG_W16,
      HASG_W32
   } hasg_width_t;

endpackage : hasg_pkg

// File: include/hasg_if.sv
// Host bus between the host sequencer and the device register side.
// Assumes both ends share one clock and a synchronous reset.
`timescale 1ns/1ps
interface hasg_if
   import hasg_pkg::*;
   (input wire logic clk);

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        req;
   logic        wr;
   hasg_addr_t  addr;
   logic [1:0]  part;
   logic        last;
   hasg_data_t  wdata;
   logic        ack;
   hasg_data_t  rdata;

   modport host (output req, wr, addr, part, last, wdata,
                 input ack, rdata);
   modport dev  (input req, wr, addr, part, last, wdata,
                 output ack, rdata);
endinterface : hasg_if

// File: logic/hasg_dev.sv
// Device end: answers host bus cycles and applies pop side effects.
// Assumes one clock shared with the host; the register fabric of the
// chip sits on the plain user-side ports.
`timescale 1ns/1ps
`include "hasg_consts.svh"
module hasg_dev
   (
   // Clock and reset
   input  wire logic         CLOCK_IN,
   input  wire logic         RST_IN,
   // Host bus
   hasg_if.dev               BUS,
   // Register fabric
   output logic              ACC_OUT,
   output logic              ACC_WR_OUT,
   output hasg_pkg::hasg_addr_t ACC_ADDR_OUT,
   output hasg_pkg::hasg_data_t ACC_WDATA_OUT,
   input  wire hasg_pkg::hasg_data_t ACC_RDATA_IN,
   input  wire logic [15:0]  RX_INFO_IN,
   input  wire logic [15:0]  TX_INFO_IN,
   input  wire logic [15:0]  TIMER_CNT_IN,
   output logic              RX_POP_OUT,
   output logic              TX_POP_OUT
   );
   import hasg_pkg::*;

   // ------------------------------------------------------------
   // Answer one cycle after each request
   // ------------------------------------------------------------
   logic       ack_r;
   hasg_data_t rdata_r;
   logic       rx_pop_r;
   logic       tx_pop_r;
   logic       pop_rd;

   // Pops happen on the final piece of a FIFO read.
   assign pop_rd = BUS.req && !BUS.wr && BUS.last;

   // Acknowledge and read data; info registers are sampled live, so the
   // pop below has settled long before the host is allowed back.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         ack_r   <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         ack_r <= BUS.req;
         unique case (BUS.addr)
            `HASG_A_RX_FIFO_INFO: rdata_r <= RX_INFO_IN;
            `HASG_A_TX_FIFO_INFO: rdata_r <= TX_INFO_IN;
            `HASG_A_TIMER_CNT:    rdata_r <= TIMER_CNT_IN;
            default:              rdata_r <= ACC_RDATA_IN;
         endcase
      end
   end

   // Pop strobes update the info counts within one cycle.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         rx_pop_r <= 1'b0;
         tx_pop_r <= 1'b0;
      end else begin
         rx_pop_r <= pop_rd && (BUS.addr == `HASG_A_RX_DATA_FIFO ||
                                BUS.addr == `HASG_A_RX_STS_FIFO);
         tx_pop_r <= pop_rd && BUS.addr == `HASG_A_TX_STS_FIFO;
      end
   end

   assign BUS.ack       = ack_r;
   assign BUS.rdata     = rdata_r;
   assign ACC_OUT       = BUS.req;
   assign ACC_WR_OUT    = BUS.wr;
   assign ACC_ADDR_OUT  = BUS.addr;
   assign ACC_WDATA_OUT = BUS.wdata;
   assign RX_POP_OUT    = rx_pop_r;
   assign TX_POP_OUT    = tx_pop_r;
endmodule : hasg_dev

// File: logic/hasg_host.sv
// Host end: sequences register accesses and stalls reads that must
// wait after a side-effecting access.
// Assumes the device answers each request with ack one cycle later.
`timescale 1ns/1ps
`include "hasg_consts.svh"
module hasg_host
   (
   // Clock and reset
   input  wire logic         CLOCK_IN,
   input  wire logic         RST_IN,
   // Command port
   input  wire logic         CMD_VALID_IN,
   output logic              CMD_READY_OUT,
   input  wire logic         CMD_WR_IN,
   input  wire hasg_pkg::hasg_addr_t CMD_ADDR_IN,
   input  wire logic [1:0]   CMD_PART_IN,
   input  wire logic         CMD_LAST_IN,
   input  wire hasg_pkg::hasg_data_t CMD_WDATA_IN,
   input  wire logic         FAB_AUTO_IN,
   output logic              RSP_VALID_OUT,
   output hasg_pkg::hasg_data_t RSP_DATA_OUT,
   // Host bus
   hasg_if.host              BUS
   );
   import hasg_pkg::*;

   // ------------------------------------------------------------
   // Spacing counts, one per guarded target
   // ------------------------------------------------------------
   // Each count is the nanosecond minimum rounded up to whole clocks.
   // The countdown starts at the go edge and the read is issued one
   // cycle after it clears, so every gap carries one clock of margin;
   // that costs a cycle per guarded read but keeps the compare simple.
   localparam int NT = 6;
   localparam logic [7:0] C_POP  = 8'(`HASG_NS2CYC(`HASG_FIFO_POP_NS));
   localparam logic [7:0] C_CSR  = 8'(`HASG_NS2CYC(`HASG_CSR_DATA_NS));
   localparam logic [7:0] C_TSLF = 8'(`HASG_NS2CYC(`HASG_TCFG_SELF_NS));
   localparam logic [7:0] C_TCNT = 8'(`HASG_NS2CYC(`HASG_TCFG_CNT_NS));
   localparam logic [7:0] C_TSC  = 8'(`HASG_NS2CYC(`HASG_TS_CFG_NS));
   localparam logic [7:0] C_TSS  = 8'(`HASG_NS2CYC(`HASG_TS_STS_NS));
   localparam logic [7:0] C_IRQ  = 8'(`HASG_NS2CYC(`HASG_IRQ_WR_NS));

   typedef enum logic [1:0] {ST_IDLE, ST_BUSY} hasg_st_t;
   hasg_st_t   st_r;
   logic [7:0] wait_r [NT];
   logic [7:0] load   [NT];
   hasg_addr_t tgt    [NT];
   logic       blocked;
   logic       go;
   logic       last_piece;

   // Targets: rx info, tx info, fabric command, timer config,
   // timer count, interrupt configuration; status regs use their own
   // countdown ts_sts_r through a separate compare below.
   assign tgt[0] = `HASG_A_RX_FIFO_INFO;
   assign tgt[1] = `HASG_A_TX_FIFO_INFO;
   assign tgt[2] = `HASG_A_FAB_CMD;
   assign tgt[3] = `HASG_A_TIMER_CFG;
   assign tgt[4] = `HASG_A_TIMER_CNT;
   assign tgt[5] = `HASG_A_IRQ_CFG;

   assign last_piece = CMD_LAST_IN;

   // Load values: each issued access arms only the pairs it touches.
   always_comb begin
      for (int i = 0; i < NT; i++) load[i] = 8'h00;
      if (go && last_piece) begin
         if (!CMD_WR_IN) begin
            if (CMD_ADDR_IN == `HASG_A_RX_DATA_FIFO ||
                CMD_ADDR_IN == `HASG_A_RX_STS_FIFO)
               load[0] = C_POP;
            if (CMD_ADDR_IN == `HASG_A_TX_STS_FIFO)
               load[1] = C_POP;
         end
         if (CMD_ADDR_IN == `HASG_A_FAB_DATA && FAB_AUTO_IN)
            load[2] = C_CSR;
         if (CMD_WR_IN) begin
            unique case (CMD_ADDR_IN)
               `HASG_A_TIMER_CFG: begin
                  load[3] = C_TSLF;
                  load[4] = C_TCNT;
               end
               `HASG_A_TS_CMD:        load[5] = C_TSC;
               `HASG_A_TS_IRQ_STS:    load[5] = C_IRQ;
               `HASG_A_TS_IRQ_EN:     load[5] = C_IRQ;
               `HASG_A_PIN_IRQ_STSEN: load[5] = C_IRQ;
               default: ;
            endcase
         end
      end
   end

   // Timestamp status follow-up after a timestamp command write.
   logic [7:0] ts_sts_r;
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) ts_sts_r <= 8'h00;
      else if (go && last_piece && CMD_WR_IN &&
               CMD_ADDR_IN == `HASG_A_TS_CMD)
         ts_sts_r <= C_TSS;
      else if (ts_sts_r != 8'h00) ts_sts_r <= ts_sts_r - 8'h01;
   end

   // Per-pair countdowns; each cycle that passes, including dummy
   // reads, counts toward the wait, so dummy reads are optional.
   for (genvar g = 0; g < NT; g++) begin : g_wait
      always_ff @(posedge CLOCK_IN) begin
         if (RST_IN) wait_r[g] <= 8'h00;
         else if (load[g] > wait_r[g]) wait_r[g] <= load[g];
         else if (wait_r[g] != 8'h00) wait_r[g] <= wait_r[g] - 8'h01;
      end
   end

   // ------------------------------------------------------------
   // Command acceptance
   // ------------------------------------------------------------
   // Beyond the busy wait, a read stalls only while its own pair still counts down.
   // Writes are held back only by the busy wait, so a write burst cannot deadlock
   // behind a countdown that only a later read cares about.
   always_comb begin
      blocked = 1'b0;
      if (!CMD_WR_IN) begin
         for (int i = 0; i < NT; i++)
            if (CMD_ADDR_IN == tgt[i] && wait_r[i] != 8'h00)
               blocked = 1'b1;
         if ((CMD_ADDR_IN == `HASG_A_GLB_IRQ_STS ||
              CMD_ADDR_IN == `HASG_A_TS_IRQ_STS) && ts_sts_r != 8'h00)
            blocked = 1'b1;
      end
   end

   assign CMD_READY_OUT = (st_r == ST_IDLE) && !blocked;
   assign go            = CMD_VALID_IN && CMD_READY_OUT;

   // ------------------------------------------------------------
   // Bus cycle
   // ------------------------------------------------------------
   // Request for one cycle, then wait for ack. Only one access is in
   // flight, which keeps the spacing arithmetic free of overlap.
   logic       req_r;
   logic       wr_r;
   hasg_addr_t addr_r;
   logic [1:0] part_r;
   logic       last_r;
   hasg_data_t wdata_r;
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         st_r    <= ST_IDLE;
         req_r   <= 1'b0;
         wr_r    <= 1'b0;
         addr_r  <= 8'h00;
         part_r  <= 2'h0;
         last_r  <= 1'b0;
         wdata_r <= 16'h0000;
      end else begin
         req_r <= go;
         unique case (st_r)
            ST_IDLE: if (go) begin
               st_r    <= ST_BUSY;
               wr_r    <= CMD_WR_IN;
               addr_r  <= CMD_ADDR_IN;
               part_r  <= CMD_PART_IN;
               last_r  <= CMD_LAST_IN;
               wdata_r <= CMD_WDATA_IN;
            end
            ST_BUSY: if (BUS.ack) st_r <= ST_IDLE;
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Response
   // ------------------------------------------------------------
   // Response capture. Writes return a pulse too, so a caller can
   // pace itself on completions alone.
   logic       rsp_v_r;
   hasg_data_t rsp_d_r;
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         rsp_v_r <= 1'b0;
         rsp_d_r <= 16'h0000;
      end else begin
         rsp_v_r <= (st_r == ST_BUSY) && BUS.ack;
         if ((st_r == ST_BUSY) && BUS.ack) rsp_d_r <= BUS.rdata;
      end
   end

   assign BUS.req       = req_r;
   assign BUS.wr        = wr_r;
   assign BUS.addr      = addr_r;
   assign BUS.part      = part_r;
   assign BUS.last      = last_r;
   assign BUS.wdata     = wdata_r;
   assign RSP_VALID_OUT = rsp_v_r;
   assign RSP_DATA_OUT  = rsp_d_r;
endmodule : hasg_host

// File: dv/hasg_bus_sva.sv
// Checker for the host bus that joins the two ends of the guard.
// Assumes the bench instantiates it beside the bus interface.
`timescale 1ns/1ps
`include "hasg_consts.svh"
module hasg_bus_sva
   (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 RST_IN,
   // Host bus
   input wire logic                 req,
   input wire logic                 wr,
   input wire hasg_pkg::hasg_addr_t addr,
   input wire logic                 last
   );
   import hasg_pkg::*;
   // ------------------------------------------------------------
   // Spacing of guarded reads
   // ------------------------------------------------------------
   // A request trails its go edge by one cycle, so each forbidden
   // span is one cycle shorter than the countdown itself.
   default clocking cb @(posedge clk); endclocking
   default disable iff (RST_IN);
   wire rd = req & ~wr;
   wire rl = rd & last;
   wire wl = req & wr & last;
   rx_data_gap_a: assert property (rl && addr == `HASG_A_RX_DATA_FIFO
      |-> not (##[1:16] (rd && addr == `HASG_A_RX_FIFO_INFO)))
      else $error("rx info read too soon after data pop");
   rx_sts_gap_a: assert property (rl && addr == `HASG_A_RX_STS_FIFO |->
      not (##[1:16] (rd && addr == `HASG_A_RX_FIFO_INFO)))
      else $error("rx info read too soon after status pop");
   tx_sts_gap_a: assert property (rl && addr == `HASG_A_TX_STS_FIFO |->
      not (##[1:16] (rd && addr == `HASG_A_TX_FIFO_INFO)))
      else $error("tx info read too soon after status pop");
   tcfg_self_a: assert property (wl && addr == `HASG_A_TIMER_CFG |->
      not (##[1:6] (rd && addr == `HASG_A_TIMER_CFG)))
      else $error("timer config read back too soon");
   tcfg_cnt_a: assert property (wl && addr == `HASG_A_TIMER_CFG |->
      not (##[1:21] (rd && addr == `HASG_A_TIMER_CNT)))
      else $error("timer count read too soon");
   ts_cfg_gap_a: assert property (wl && addr == `HASG_A_TS_CMD |->
      not (##[1:8] (rd && addr == `HASG_A_IRQ_CFG)))
      else $error("irq config read too soon after ts command");
   ts_sts_gap_a: assert property (wl && addr == `HASG_A_TS_CMD |->
      not (##[1:6] (rd && (addr == `HASG_A_GLB_IRQ_STS ||
      addr == `HASG_A_TS_IRQ_STS))))
      else $error("irq status read too soon after ts command");
   irq_wr_gap_a: assert property (wl &&
      (addr == `HASG_A_TS_IRQ_STS ||
      addr == `HASG_A_TS_IRQ_EN || addr == `HASG_A_PIN_IRQ_STSEN) |->
      not (##[1:7] (rd && addr == `HASG_A_IRQ_CFG)))
      else $error("irq config read too soon after irq write");
   cover property (rl && addr == `HASG_A_RX_DATA_FIFO);
   cover property (wl && addr == `HASG_A_TIMER_CFG);
   cover property (rd && addr == `HASG_A_FAB_CMD);
endmodule : hasg_bus_sva

// File: dv/tb_host_access_spacing_guard.sv
// Bench joining the host and device ends over the bus interface.
// Assumes the design and include folders are on the search path.
`timescale 1ns/1ps
`include "hasg_consts.svh"
module tb_host_access_spacing_guard;
   import hasg_pkg::*;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   logic       clk, rst, vld, wr, last, fab, rdy, rsp, rxp, txp;
   logic [1:0] part;
   hasg_addr_t addr;
   hasg_data_t rsp_data, rsp_d, rx_info, tx_info, acc_wd;
   logic       acc_v, acc_w;
   hasg_addr_t acc_a;
   int         n_fail, n_compared, cyc;
   hasg_if u_hasg_if (.clk(clk));
   hasg_host u_hasg_host (.CLOCK_IN(clk), .RST_IN(rst), .CMD_VALID_IN(vld),
      .CMD_READY_OUT(rdy), .CMD_WR_IN(wr), .CMD_ADDR_IN(addr),
      .CMD_PART_IN(part), .CMD_LAST_IN(last), .CMD_WDATA_IN({8'h5a, addr}),
      .FAB_AUTO_IN(fab), .RSP_VALID_OUT(rsp), .RSP_DATA_OUT(rsp_data),
      .BUS(u_hasg_if));
   hasg_dev u_hasg_dev (.CLOCK_IN(clk), .RST_IN(rst), .BUS(u_hasg_if),
      .ACC_OUT(acc_v), .ACC_WR_OUT(acc_w), .ACC_ADDR_OUT(acc_a),
      .ACC_WDATA_OUT(acc_wd),
      .ACC_RDATA_IN(16'h7788), .RX_INFO_IN(rx_info), .TX_INFO_IN(tx_info),
      .TIMER_CNT_IN(16'h5e6f), .RX_POP_OUT(rxp), .TX_POP_OUT(txp));
   hasg_bus_sva u_hasg_bus_sva (.clk(clk), .RST_IN(rst),
      .req(u_hasg_if.req), .wr(u_hasg_if.wr), .addr(u_hasg_if.addr),
      .last(u_hasg_if.last));
   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Info values step on each pop, so a stale read shows up as a miss.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rxp === 1'b1)
         rx_info <= rx_info + 16'h0001;
      if (txp === 1'b1)
         tx_info <= tx_info + 16'h0001;
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One access; ready is looked at on the falling edge, where it has
   // settled, and g returns the cycle of the go edge.
   task automatic acc(input logic w, input hasg_addr_t a, input logic l,
                      output int g);
      int k;
      k = 0;
      @(posedge clk);
      vld  <= 1'b1;
      wr   <= w;
      addr <= a;
      last <= l;
      part <= {1'b0, l};
      @(negedge clk);
      while (rdy !== 1'b1 && k < 100) begin
         k++;
         @(negedge clk);
      end
      @(posedge clk);
      g = cyc;
      vld <= 1'b0;
      k = 0;
      @(negedge clk);
      // The request stands on the fabric side for this one cycle.
      chk({acc_v, acc_w, acc_a, acc_wd}, {1'b1, w, a, 8'h5a, a});
      while (rsp !== 1'b1 && k < 20) begin
         k++;
         @(negedge clk);
      end
      chk(rsp, 1'b1);
      rsp_d = rsp_data;
   endtask : acc
   // First access, then a read at once; n is the least go spacing,
   // zero where the pair is unguarded.
   task automatic pair(input logic w, input hasg_addr_t a1,
                       input logic l, input hasg_addr_t a2, input int n);
      int g1, g2;
      repeat (25) @(posedge clk);
      acc(w, a1, l, g1);
      acc(1'b0, a2, 1'b1, g2);
      if (n > 0)
         chk(g2 - g1 >= n && g2 - g1 <= n + 1, 1'b1);
      else
         chk(g2 - g1 < 7, 1'b1);
   endtask : pair
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_pieces;
      pair(1'b0, `HASG_A_RX_DATA_FIFO, 1'b0, `HASG_A_RX_FIFO_INFO, 0);
      chk(rsp_d, 16'h0100);
   endtask : t_pieces
   task automatic t_fifo;
      pair(1'b0, `HASG_A_RX_DATA_FIFO, 1'b1, `HASG_A_RX_FIFO_INFO, 17);
      chk(rsp_d, 16'h0101);
      pair(1'b0, `HASG_A_RX_STS_FIFO, 1'b1, `HASG_A_RX_FIFO_INFO, 17);
      chk(rsp_d, 16'h0102);
      pair(1'b0, `HASG_A_TX_STS_FIFO, 1'b1, `HASG_A_TX_FIFO_INFO, 17);
      chk(rsp_d, 16'h0201);
   endtask : t_fifo
   task automatic t_fabric;
      @(posedge clk);
      fab <= 1'b1;
      pair(1'b1, `HASG_A_FAB_DATA, 1'b1, `HASG_A_FAB_CMD, 7);
      pair(1'b0, `HASG_A_FAB_DATA, 1'b1, `HASG_A_FAB_CMD, 7);
      @(posedge clk);
      fab <= 1'b0;
      pair(1'b0, `HASG_A_FAB_DATA, 1'b1, `HASG_A_FAB_CMD, 0);
      chk(rsp_d, 16'h7788);
   endtask : t_fabric
   task automatic t_timer;
      pair(1'b1, `HASG_A_TIMER_CFG, 1'b1, `HASG_A_TIMER_CFG, 7);
      pair(1'b1, `HASG_A_TIMER_CFG, 1'b1, `HASG_A_TIMER_CNT, 22);
      chk(rsp_d, 16'h5e6f);
   endtask : t_timer
   task automatic t_irq;
      pair(1'b1, `HASG_A_TS_CMD, 1'b1, `HASG_A_IRQ_CFG, 9);
      pair(1'b1, `HASG_A_TS_CMD, 1'b1, `HASG_A_GLB_IRQ_STS, 7);
      pair(1'b1, `HASG_A_TS_CMD, 1'b1, `HASG_A_TS_IRQ_STS, 7);
      pair(1'b1, `HASG_A_TS_IRQ_STS, 1'b1, `HASG_A_IRQ_CFG, 8);
      pair(1'b1, `HASG_A_TS_IRQ_EN, 1'b1, `HASG_A_IRQ_CFG, 8);
      pair(1'b1, `HASG_A_PIN_IRQ_STSEN, 1'b1, `HASG_A_IRQ_CFG, 8);
   endtask : t_irq
   task automatic conclude;
      $display("checks %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // Main sequence after a twelve-cycle reset.
   initial begin
      {vld, wr, last, fab, part, addr} = '0;
      {n_fail, n_compared, cyc} = '0;
      rx_info = 16'h0100;
      tx_info = 16'h0200;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_pieces;
      t_fifo;
      t_fabric;
      t_timer;
      t_irq;
      conclude;
   end
   // Watchdog, far beyond the roughly six hundred cycles the tests need.
   initial begin
      repeat (4000) @(posedge clk);
      n_fail++;
      conclude;
   end
endmodule : tb_host_access_spacing_guard
